// ===== rcg_consts.svh
// Purpose: Named constants for the reference clock generator.
// Assumes: Included by the package and the top module.
// Notes: Offsets are byte addresses on the APB bus.
`ifndef RCG_CONSTS_SVH
`define RCG_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RCG_ADDR_W 12
`define RCG_OFS_TUNE 12'h000
`define RCG_OFS_CTRL 12'h004
`define RCG_OFS_TRIM 12'h008
`define RCG_OFS_UNLOCK 12'h00c
`define RCG_UNLOCK_KEY1 32'haa996655
`define RCG_UNLOCK_KEY2 32'h556699aa

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCG_TUNE_MSB 5
`define RCG_DIV_MSB 30
`define RCG_DIV_LSB 16
`define RCG_BIT_ON 15
`define RCG_BIT_IDLE_STOP 13
`define RCG_BIT_PIN_OE 12
`define RCG_BIT_RUN_SLEEP 11
`define RCG_BIT_DIV_SWITCH 9
`define RCG_BIT_ACTIVE 8
`define RCG_SEL_MSB 3
`define RCG_TRIM_MSB 31
`define RCG_TRIM_LSB 23

// ----------------------------------------------------------------
// Widths, reset values and codes
// ----------------------------------------------------------------
`define RCG_DIV_W 15
`define RCG_TRIM_W 9
`define RCG_TUNE_W 6
`define RCG_SEL_W 4
`define RCG_NSRC 9
`define RCG_TUNE_RST 6'h00
`define RCG_DIV_RST 15'h0000
`define RCG_TRIM_RST 9'h000
`define RCG_SEL_RST 4'h0
`define RCG_SEL_SYSTEM_CLOCK 4'h0
`define RCG_SEL_PERIPHERAL_BUS_CLOCK 4'h1
`define RCG_SEL_LAST 4'h8
`define RCG_FRC_NOMINAL_MHZ 8

`endif

// ===== rcg_monitor.sv
// Purpose: Port checker for the reference clock generator.
// Assumes: Sees only the ports of rcg_top.
// Notes: Bound at the foot of this file.
`timescale 1ns/1ps
`include "rcg_consts.svh"
module rcg_monitor (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RCG_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Outputs
  input wire logic [`RCG_TUNE_W-1:0] frc_tuning_code,
  input wire logic reference_clock_out_pin,
  input wire logic reference_clock_out_oe
);
  // ----
  // Checks
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  logic wr_tune;
  logic wr_ctrl;
  assign rd_acc = psel && penable && !pwrite;
  assign wr_tune = psel && penable && pwrite && paddr == `RCG_OFS_TUNE;
  assign wr_ctrl = psel && penable && pwrite && paddr == `RCG_OFS_CTRL;
  property p_tune_hi;
    rd_acc && paddr == `RCG_OFS_TUNE |-> prdata[31:6] == 26'h0;
  endproperty
  a_tune_hi: assert property (p_tune_hi) else $error("tune high bits set");
  property p_ctrl_rsv;
    rd_acc && paddr == `RCG_OFS_CTRL |-> {prdata[31], prdata[14], prdata[10], prdata[7:4]} == 7'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control spare bits set");
  property p_trim_lo;
    rd_acc && paddr == `RCG_OFS_TRIM |-> prdata[22:0] == 23'h0;
  endproperty
  a_trim_lo: assert property (p_trim_lo) else $error("trim low bits set");
  property p_pin_off;
    !reference_clock_out_oe [*2] |-> !reference_clock_out_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
  property p_tune_src;
    $changed(frc_tuning_code) |-> $past(wr_tune) || $past(wr_tune, 2);
  endproperty
  a_tune_src: assert property (p_tune_src) else $error("tune moved unwritten");
  property p_tune_rst;
    $rose(presetn) |-> frc_tuning_code == 6'h00;
  endproperty
  a_tune_rst: assert property (p_tune_rst) else $error("tune not zero at reset");
  property p_oe_src;
    $changed(reference_clock_out_oe) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("enable moved unwritten");
  property p_unmapped;
    psel && penable && paddr > `RCG_OFS_UNLOCK |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
endmodule

bind rcg_top rcg_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .frc_tuning_code(frc_tuning_code), .reference_clock_out_pin(reference_clock_out_pin),
  .reference_clock_out_oe(reference_clock_out_oe));

// ===== rcg_pin_load.sv
// Purpose: Load on the clock pin that times its rising edges.
// Assumes: Pin is sampled on pclk.
// Notes: An undriven pin is pulled low.
`timescale 1ns/1ps
module rcg_pin_load (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin
  input wire logic pin,
  input wire logic oe,
  // Measurements
  output logic [15:0] period,
  output logic [15:0] n_edges
);
  // ----
  // Edge timer
  // ----
  logic lvl;
  logic lvl_d;
  logic [15:0] run;
  assign lvl = oe ? pin : 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_d <= 1'b0;
      run <= 16'h0;
      period <= 16'h0;
      n_edges <= 16'h0;
    end else begin
      lvl_d <= lvl;
      run <= run + 16'h1;
      if (lvl && !lvl_d) begin
        run <= 16'h0;
        period <= run + 16'h1;
        n_edges <= n_edges + 16'h1;
      end
    end
  end
endmodule

// ===== rcg_pkg.sv
// Purpose: Types for the reference clock generator.
// Assumes: rcg_consts.svh is on the include path.
// Notes: Control fields travel as one packed struct.
`include "rcg_consts.svh"

package rcg_pkg;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic on;
    logic idle_stop;
    logic pin_oe;
    logic run_in_sleep;
    logic [`RCG_SEL_W-1:0] source_select;
  } rcg_ctl_t;

  // ----------------------------------------------------------------
  // Power modes and unlock states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCG_RUN = 3'b001,
    RCG_IDLE = 3'b010,
    RCG_SLEEP = 3'b100
  } rcg_pmode_t;

  typedef enum logic [2:0] {
    RCG_LOCKED = 3'b001,
    RCG_KEY1 = 3'b010,
    RCG_OPEN = 3'b100
  } rcg_lock_t;

endpackage

// ===== rcg_tb.sv
// Purpose: Self-checking bench for the reference clock generator.
// Assumes: Source i is a square wave with a half period of 4 + i cycles.
// Notes: Periods are measured in pclk cycles.
`timescale 1ns/1ps
`include "rcg_consts.svh"
module tb;
  // ----
  // Bench
  // ----
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] clk_src = 9'h0;
  logic sleep_select = 1'b0;
  logic wait_exec = 1'b0;
  logic wake = 1'b0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic err;
  logic pin;
  logic oe;
  logic [5:0] code;
  logic [15:0] period;
  logic [15:0] n_edges;
  int sc [9] = '{default: 0};
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      give_verdict();
    end
    for (int i = 0; i < 9; i++) begin
      sc[i] <= (sc[i] == 3 + i) ? 0 : sc[i] + 1;
      if (sc[i] == 3 + i) clk_src[i] <= ~clk_src[i];
    end
  end
  rcg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_src(clk_src), .sleep_select(sleep_select),
    .wait_exec(wait_exec), .wake(wake), .frc_tuning_code(code),
    .reference_clock_out_pin(pin), .reference_clock_out_oe(oe));
  rcg_pin_load u_load (.pclk(pclk), .presetn(presetn), .pin(pin), .oe(oe),
    .period(period), .n_edges(n_edges));
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wc(input logic [31:0] d);
    apb(1'b1, `RCG_OFS_CTRL, d);
  endtask
  task automatic runs(input logic exp);
    logic [15:0] e0;
    repeat (10) @(posedge pclk);
    e0 = n_edges;
    repeat (300) @(posedge pclk);
    chk(32'(n_edges != e0), 32'(exp));
  endtask
  task automatic meas(input logic [15:0] exp);
    logic [15:0] e0;
    int n;
    e0 = n_edges;
    n = 0;
    while (n_edges - e0 < 16'h3 && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(period), 32'(exp));
  endtask
  task automatic mode(input logic slp, input logic go);
    sleep_select <= slp;
    wait_exec <= go;
    wake <= !go;
    @(posedge pclk);
    wait_exec <= 1'b0;
    wake <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tune_open(input logic [31:0] d);
    apb(1'b1, `RCG_OFS_UNLOCK, `RCG_UNLOCK_KEY1);
    apb(1'b1, `RCG_OFS_UNLOCK, `RCG_UNLOCK_KEY2);
    apb(1'b1, `RCG_OFS_TUNE, d);
  endtask
  task automatic switch_div(input logic [31:0] c);
    int n;
    n = 0;
    wc(c | 32'h200);
    rd(`RCG_OFS_CTRL, c | 32'h300);
    while (q[9] !== 1'b0 && n < 100) begin
      n++;
      apb(1'b0, `RCG_OFS_CTRL, 32'h0);
    end
    chk(32'(q[9]), 32'h0);
  endtask
  task automatic t_reset();
    rd(`RCG_OFS_TUNE, 32'h0);
    rd(`RCG_OFS_CTRL, 32'h0);
    rd(`RCG_OFS_TRIM, 32'h0);
    rd(12'h010, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  task automatic t_tune();
    apb(1'b1, `RCG_OFS_TUNE, 32'hffff_ffe0);
    rd(`RCG_OFS_TUNE, 32'h0);
    tune_open(32'hffff_ffe0);
    rd(`RCG_OFS_TUNE, 32'h20);
    chk(32'(code), 32'h20);
    apb(1'b1, `RCG_OFS_TUNE, 32'h1f);
    rd(`RCG_OFS_TUNE, 32'h20);
    tune_open(32'h1f);
    rd(`RCG_OFS_TUNE, 32'h1f);
    tune_open(32'h0);
    chk(32'(code), 32'h0);
  endtask
  task automatic t_fields();
    wc(32'hffff_79ff);
    rd(`RCG_OFS_CTRL, 32'h7fff_380f);
    apb(1'b1, `RCG_OFS_TRIM, 32'hffff_ffff);
    rd(`RCG_OFS_TRIM, 32'hff80_0000);
    apb(1'b1, `RCG_OFS_TRIM, 32'h0);
  endtask
  task automatic t_sources();
    for (int i = 0; i < 10; i++) begin
      wc(32'(i));
      wc(32'h9000 | 32'(i));
      if (i < 9) meas(16'(8 + 2 * i));
      else runs(1'b0);
    end
    wc(32'h8002);
    runs(1'b0);
    chk(32'(oe), 32'h0);
  endtask
  task automatic t_divide();
    wc(32'h0003_1002);
    wc(32'h0003_9002);
    meas(16'd72);
    wc(32'h0001_9002);
    meas(16'd72);
    switch_div(32'h0001_9002);
    meas(16'd24);
    apb(1'b1, `RCG_OFS_TRIM, 32'h8000_0000);
    meas(16'd24);
    switch_div(32'h0001_9002);
    meas(16'd36);
  endtask
  task automatic t_power();
    wc(32'h0001_b002);
    mode(1'b0, 1'b1);
    runs(1'b0);
    rd(`RCG_OFS_CTRL, 32'h0001_b002);
    mode(1'b0, 1'b0);
    rd(`RCG_OFS_CTRL, 32'h0001_b102);
    wc(32'h0001_9002);
    mode(1'b0, 1'b1);
    runs(1'b1);
    mode(1'b1, 1'b0);
    mode(1'b1, 1'b1);
    runs(1'b0);
    mode(1'b1, 1'b0);
    wc(32'h0001_9802);
    mode(1'b1, 1'b1);
    runs(1'b1);
    mode(1'b1, 1'b0);
    wc(32'h0001_0801);
    wc(32'h0001_9801);
    mode(1'b1, 1'b1);
    runs(1'b0);
    mode(1'b1, 1'b0);
    wc(32'h0001_1801);
    runs(1'b0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tune();
    t_fields();
    t_sources();
    t_divide();
    t_power();
    give_verdict();
  end
endmodule

// ===== rcg_top.sv
// Purpose: Reference clock generator with RC oscillator tuning register.
// Assumes: All clock sources are asynchronous to pclk and slow enough to sample.
// Notes: Source edges are seen as one-cycle enables after a two-flop synchroniser.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "rcg_consts.svh"

// Notes on behaviour
// RULE1: Six-bit tuning field, upper bits read zero.
// RULE2: Tuning code is signed offset, +/-12.5 percent.
// RULE3: Tuning zero keeps fast RC at 8 MHz.
// RULE4: Tuning writes need prior unlock sequence.
// RULE5: Divider N divides by 2N, zero passes.
// RULE6: Module enable turns whole module on/off.
// RULE7: Idle-stop halts module during Idle.
// RULE8: Pin enable drives clock on output pin.
// RULE9: Run-in-sleep keeps output running in Sleep.
// RULE10: Run-in-sleep ignored for system/peripheral clock.
// RULE11: Divider switch set by software, hardware cleared.
// RULE12: Request status shows active request, read-only.
// RULE13: Running divider writes wait for divider switch.
// RULE14: Software avoids select/divider writes while active.
// RULE15: Select codes zero to four pick sources.
// RULE16: Codes five to eight more; rest reserved.
// RULE17: Unimplemented control bits read as zero.
// RULE18: Nine-bit trim adds N/512 to divider.
// RULE19: Trim low bits zero, resets zero.
// RULE20: Running trim writes wait for divider switch.
// RULE21: Wait enters Sleep or Idle per select.
// RULE22: Fractional accumulator averages 2(N+T/512) periods.
// RULE23: Changes applied at output boundary, no runts.
module rcg_top
  import rcg_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RCG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources, indexed by select code
  input wire logic [`RCG_NSRC-1:0] clk_src,
  // Power management
  input wire logic sleep_select,
  input wire logic wait_exec,
  input wire logic wake,
  // Oscillator tuning and output pin
  output logic [`RCG_TUNE_W-1:0] frc_tuning_code,
  output logic reference_clock_out_pin,
  output logic reference_clock_out_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rcg_ctl_t ctl;
  rcg_pmode_t pmode;
  rcg_lock_t lock;
  logic [`RCG_TUNE_W-1:0] tuning_code;
  logic [`RCG_DIV_W-1:0] integer_divider;
  logic [`RCG_TRIM_W-1:0] fractional_trim;
  logic [`RCG_DIV_W-1:0] act_div;
  logic [`RCG_TRIM_W-1:0] act_trim;
  logic [`RCG_SEL_W-1:0] act_sel;
  logic divider_switch;
  logic [`RCG_NSRC-1:0] src_meta;
  logic [`RCG_NSRC-1:0] src_sync;
  logic src_lvl;
  logic src_prev;
  logic src_rise;
  logic src_fall;
  logic [`RCG_DIV_W:0] cnt;
  logic [`RCG_DIV_W:0] limit;
  logic [`RCG_TRIM_W-1:0] acc;
  logic [`RCG_TRIM_W:0] next_acc;
  logic extra;
  logic gen_clk;
  logic running;
  logic toggle;
  logic boundary;
  logic wr;
  logic rd_ok;
  logic sleep_ok;

  function automatic logic hit(input logic [`RCG_ADDR_W-1:0] a,
                               input logic [`RCG_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign rd_ok = hit(paddr, `RCG_OFS_TUNE) || hit(paddr, `RCG_OFS_CTRL) ||
                 hit(paddr, `RCG_OFS_TRIM) || hit(paddr, `RCG_OFS_UNLOCK);
  assign pslverr = psel && penable && !rd_ok;

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit(paddr, `RCG_OFS_TUNE)) begin
      prdata[`RCG_TUNE_MSB:0] = tuning_code; // [RULE1]
    end else if (hit(paddr, `RCG_OFS_CTRL)) begin
      prdata[`RCG_DIV_MSB:`RCG_DIV_LSB] = integer_divider;
      prdata[`RCG_BIT_ON] = ctl.on;
      prdata[`RCG_BIT_IDLE_STOP] = ctl.idle_stop;
      prdata[`RCG_BIT_PIN_OE] = ctl.pin_oe;
      prdata[`RCG_BIT_RUN_SLEEP] = ctl.run_in_sleep;
      prdata[`RCG_BIT_DIV_SWITCH] = divider_switch; // [RULE11]
      prdata[`RCG_BIT_ACTIVE] = running; // [RULE12]
      prdata[`RCG_SEL_MSB:0] = ctl.source_select; // [RULE17]
    end else if (hit(paddr, `RCG_OFS_TRIM)) begin
      prdata[`RCG_TRIM_MSB:`RCG_TRIM_LSB] = fractional_trim; // [RULE19]
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence and tuning register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= RCG_LOCKED;
    end else if (wr && hit(paddr, `RCG_OFS_UNLOCK)) begin
      unique case (lock)
        RCG_LOCKED: lock <= (pwdata == `RCG_UNLOCK_KEY1) ? RCG_KEY1 : RCG_LOCKED;
        RCG_KEY1: lock <= (pwdata == `RCG_UNLOCK_KEY2) ? RCG_OPEN : RCG_LOCKED;
        RCG_OPEN: lock <= RCG_OPEN;
        default: lock <= RCG_LOCKED;
      endcase
    end else if (wr && hit(paddr, `RCG_OFS_TUNE)) begin
      lock <= RCG_LOCKED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tuning_code <= `RCG_TUNE_RST; // [RULE1] [RULE3]
    end else if (wr && hit(paddr, `RCG_OFS_TUNE) && lock == RCG_OPEN) begin
      tuning_code <= pwdata[`RCG_TUNE_MSB:0]; // [RULE4]
    end
  end

  // Two's complement code goes straight to the oscillator trim.
  assign frc_tuning_code = tuning_code; // [RULE2]

  // ----------------------------------------------------------------
  // Control and trim registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= '0; // [RULE6]
      integer_divider <= `RCG_DIV_RST;
    end else if (wr && hit(paddr, `RCG_OFS_CTRL)) begin
      ctl.on <= pwdata[`RCG_BIT_ON];
      ctl.idle_stop <= pwdata[`RCG_BIT_IDLE_STOP];
      ctl.pin_oe <= pwdata[`RCG_BIT_PIN_OE];
      ctl.run_in_sleep <= pwdata[`RCG_BIT_RUN_SLEEP];
      ctl.source_select <= pwdata[`RCG_SEL_MSB:0];
      integer_divider <= pwdata[`RCG_DIV_MSB:`RCG_DIV_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fractional_trim <= `RCG_TRIM_RST; // [RULE19]
    end else if (wr && hit(paddr, `RCG_OFS_TRIM)) begin
      fractional_trim <= pwdata[`RCG_TRIM_MSB:`RCG_TRIM_LSB]; // [RULE18]
    end
  end

  // A write that sets the switch bit wins over the completion clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_switch <= 1'b0;
    end else if (wr && hit(paddr, `RCG_OFS_CTRL) && pwdata[`RCG_BIT_DIV_SWITCH] &&
                 ctl.on) begin
      divider_switch <= 1'b1; // [RULE11]
    end else if (boundary || !ctl.on) begin
      divider_switch <= 1'b0; // [RULE11] [RULE23]
    end
  end

  // Divisor in use: follows the written value at once when off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_div <= `RCG_DIV_RST;
      act_trim <= `RCG_TRIM_RST;
    end else if (!ctl.on || (divider_switch && boundary)) begin
      act_div <= integer_divider; // [RULE13]
      act_trim <= fractional_trim; // [RULE20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel <= `RCG_SEL_RST;
    end else if (!running || boundary) begin
      act_sel <= ctl.source_select; // [RULE23]
    end
  end

  // ----------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmode <= RCG_RUN;
    end else begin
      unique case (pmode)
        RCG_RUN: if (wait_exec) begin
          pmode <= sleep_select ? RCG_SLEEP : RCG_IDLE; // [RULE21]
        end
        RCG_IDLE: if (wake) begin
          pmode <= RCG_RUN;
        end
        RCG_SLEEP: if (wake) begin
          pmode <= RCG_RUN;
        end
        default: pmode <= RCG_RUN;
      endcase
    end
  end

  assign sleep_ok = ctl.run_in_sleep && act_sel != `RCG_SEL_SYSTEM_CLOCK &&
                    act_sel != `RCG_SEL_PERIPHERAL_BUS_CLOCK; // [RULE9] [RULE10]
  assign running = ctl.on && !(pmode == RCG_IDLE && ctl.idle_stop) &&
                   !(pmode == RCG_SLEEP && !sleep_ok); // [RULE6] [RULE7]

  // ----------------------------------------------------------------
  // Source synchronisers and selection
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `RCG_NSRC; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_meta[i] <= 1'b0;
        src_sync[i] <= 1'b0;
      end else begin
        src_meta[i] <= clk_src[i];
        src_sync[i] <= src_meta[i];
      end
    end
  end

  // Reserved codes select a source that never moves.
  always_comb begin
    src_lvl = 1'b0;
    if (act_sel <= `RCG_SEL_LAST) begin
      src_lvl = src_sync[act_sel]; // [RULE15] [RULE16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_lvl;
    end
  end

  assign src_rise = src_lvl && !src_prev;
  assign src_fall = !src_lvl && src_prev;

  // ----------------------------------------------------------------
  // Divider with fractional accumulator
  // ----------------------------------------------------------------
  assign limit = {1'b0, act_div} + {{`RCG_DIV_W{1'b0}}, extra};
  assign toggle = running && act_div != `RCG_DIV_RST && src_rise &&
                  (cnt + 16'h0001) >= limit; // [RULE5] [RULE22]
  assign next_acc = {1'b0, acc} + {1'b0, act_trim};
  assign boundary = !running || (toggle && gen_clk) ||
                    (act_div == `RCG_DIV_RST && src_fall); // [RULE23]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      acc <= `RCG_TRIM_RST;
      extra <= 1'b0;
      gen_clk <= 1'b0;
    end else if (!running) begin
      cnt <= 16'h0000; // [RULE6]
      acc <= `RCG_TRIM_RST;
      extra <= 1'b0;
      gen_clk <= 1'b0;
    end else if (act_div == `RCG_DIV_RST) begin
      gen_clk <= src_lvl; // [RULE5]
    end else if (toggle) begin
      cnt <= 16'h0000;
      acc <= next_acc[`RCG_TRIM_W-1:0]; // [RULE22]
      extra <= next_acc[`RCG_TRIM_W];
      gen_clk <= !gen_clk;
    end else if (src_rise) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_clock_out_pin <= 1'b0;
      reference_clock_out_oe <= 1'b0;
    end else begin
      reference_clock_out_pin <= gen_clk && ctl.pin_oe; // [RULE8]
      reference_clock_out_oe <= ctl.on && ctl.pin_oe; // [RULE8]
    end
  end

endmodule
